// ---- core/low_power_mode_controller.sv ----
// power-mode controller: power states, reset sequence, boot
// Operation
// - regulator normal in run and sleep
// - low and extra-low regulator only in deepsleep
// - standby: regulator off, core off, contents lost
// - regulator normal after any reset
// - sleep halts core only, any event resumes
// - deepsleep stops pll and fast clocks, retains
// - deepsleep regulator mode chosen by software
// - any enabled wake line leaves deepsleep
// - standby powers off domain, pll, oscillators
// - only always-on state survives standby; the wake-line pending flags are also kept
// - reset pin, watchdog, wake pin, calendar leave standby
// - calendar and watchdog clocks always run
// - boot pin and option bit pick source
// - default clock internal oscillator divided by six
// - per-line edge select and mask
//
// Added by the designer: the AHB-Lite register port and the address map.
module low_power_mode_controller (
   input wire logic clk_in, // system clock
   input wire logic rst_n_in, // sync reset, active low
   input wire logic hsel_in, // ahb select
   input wire logic [31:0] haddr_in, // ahb address
   input wire logic [1:0] htrans_in, // ahb transfer type
   input wire logic hwrite_in, // ahb write
   input wire logic [2:0] hsize_in, // ahb size
   input wire logic [31:0] hwdata_in, // ahb write data
   input wire logic hready_in, // ahb ready
   output logic [31:0] hrdata_out, // ahb read data
   output logic hreadyout_out, // ahb slave ready
   output logic hresp_out, // ahb response
   input wire logic core_sleep_req_in, // sleep request pulse
   input wire logic core_event_in, // core interrupt or event
   input wire logic [15:0] external_interrupt_line_in, // pin lines
   input wire logic supply_voltage_monitor_in, // voltage monitor
   input wire logic calendar_clock_alarm_in, // calendar alarm
   input wire logic calendar_clock_tamper_in, // calendar tamper
   input wire logic calendar_clock_stamp_in, // calendar time stamp
   input wire logic analog_comparator_wake_in, // comparator wake
   input wire logic external_reset_pin_n_in, // reset pin, active low
   input wire logic independent_watchdog_reset_in, // watchdog reset
   input wire logic [3:0] wake_pin_in, // standby wake pins
   input wire logic boot_select_pin_in, // boot pin
   input wire logic boot_option_bit_in, // stored boot option
   output logic core_halt_out, // core clock stopped
   output logic sys_reset_n_out, // system reset, low
   output logic [1:0] regulator_mode_out, // regulator mode
   output logic domain_power_out, // regulated domain powered
   output logic retain_out, // contents kept
   output logic pll_en_out, // pll enable
   output logic internal_fast_osc_en_out, // fast osc enable
   output logic external_fast_crystal_en_out, // crystal oscillator enable
   output logic calendar_clock_clk_en_out, // calendar clk enable
   output logic independent_watchdog_clk_en_out, // watchdog clk enable
   output logic [1:0] boot_source_out, // boot source
   output logic [1:0] sysclk_src_out, // system clock source
   output logic [2:0] sysclk_div_out, // system clock divider
   output logic [2:0] pm_state_out // power state
);
   // bus side
   logic [11:0] addr; // data-phase offset
   logic wr_en; // write strobe
   logic rd_en; // read capture
   logic [31:0] rdata; // read mux
   // config, lost across standby
   logic [7:0] ctrl_ff; // mode control
   logic [19:0] rise_ff; // rising-edge enables
   logic [19:0] fall_ff; // falling-edge enables
   logic [19:0] mask_ff; // line enables
   logic [3:0] pinen_ff; // wake pin enables
   // always-on state
   lpm_pkg::pm_state_t state_ff; // power state
   lpm_pkg::pm_state_t nxt_state; // next state
   logic [3:0] seq_cnt_ff; // reset sequence counter
   logic [1:0] boot_ff; // latched boot source
   logic stby_flag_ff; // woke from standby
   // pin synchronisers
   logic [7:0] pin_meta_ff; // first stage
   logic [7:0] pin_sync_ff; // second stage
   logic [3:0] wpin_prev_ff; // last wake pin level
   // wake lines
   logic [19:0] pend; // pending lines
   logic [19:0] line_rise; // raw rising edges
   logic [19:0] pend_clr; // clear pulses

   ahb_word_port u_port (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .hsel_in(hsel_in),
      .haddr_in(haddr_in),
      .htrans_in(htrans_in),
      .hwrite_in(hwrite_in),
      .hsize_in(hsize_in),
      .hready_in(hready_in),
      .rdata_in(rdata),
      .addr_out(addr),
      .wr_en_out(wr_en),
      .rd_en_out(rd_en),
      .hrdata_out(hrdata_out),
      .hreadyout_out(hreadyout_out),
      .hresp_out(hresp_out)
   );

   // lines: pins, monitor, alarm or tamper, stamp, comparator
   wire [19:0] lines = {analog_comparator_wake_in, calendar_clock_stamp_in,
      calendar_clock_alarm_in | calendar_clock_tamper_in,
      supply_voltage_monitor_in, external_interrupt_line_in};

   wake_line_detect u_lines (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .line_in(lines),
      .rise_en_in(rise_ff),
      .fall_en_in(fall_ff),
      .mask_in(mask_ff),
      .clr_in(pend_clr),
      .pend_out(pend),
      .rise_evt_out(line_rise)
   );

   // register decode
   wire sel_ctrl = addr == lpm_pkg::CTRL_OFS;
   wire sel_rise = addr == lpm_pkg::RISE_OFS;
   wire sel_fall = addr == lpm_pkg::FALL_OFS;
   wire sel_mask = addr == lpm_pkg::MASK_OFS;
   wire sel_pend = addr == lpm_pkg::PEND_OFS;
   wire sel_stat = addr == lpm_pkg::STAT_OFS;
   wire sel_pinen = addr == lpm_pkg::PINEN_OFS;
   assign pend_clr = (wr_en & sel_pend) ? hwdata_in[19:0] : 20'h00000;

   // status word
   wire [31:0] stat_word = {23'h000000, stby_flag_ff, 2'h0, boot_ff, 1'b0, state_ff};

   // read mux; unmapped offsets read zero
   assign rdata = !rd_en ? 32'h00000000 :
      sel_ctrl ? {24'h000000, ctrl_ff} :
      sel_rise ? {12'h000, rise_ff} :
      sel_fall ? {12'h000, fall_ff} :
      sel_mask ? {12'h000, mask_ff} :
      sel_pend ? {12'h000, pend} :
      sel_stat ? stat_word :
      sel_pinen ? {28'h0000000, pinen_ff} : 32'h00000000;

   // synchronised pins
   wire [3:0] wpin_sync = pin_sync_ff[3:0];
   wire rst_pin_low = ~pin_sync_ff[4];
   wire wdt_rst = pin_sync_ff[5];
   wire boot_pin = pin_sync_ff[6];
   wire boot_opt = pin_sync_ff[7];

   // two flops on every loose pin
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pin_meta_ff <= lpm_pkg::PIN_SYNC_RST;
         pin_sync_ff <= lpm_pkg::PIN_SYNC_RST;
         wpin_prev_ff <= 4'h0;
      end else begin
         pin_meta_ff <= {boot_option_bit_in, boot_select_pin_in, independent_watchdog_reset_in,
            external_reset_pin_n_in, wake_pin_in};
         pin_sync_ff <= pin_meta_ff;
         wpin_prev_ff <= wpin_sync;
      end
   end

   // wake conditions
   wire wpin_rise = |(wpin_sync & ~wpin_prev_ff & pinen_ff);
   wire cal_rise = line_rise[17] | line_rise[18]; // calendar lines
   wire any_pend = |pend;
   wire force_reset = rst_pin_low | wdt_rst;
   wire stby_wake = wpin_rise | cal_rise;
   wire seq_done = (seq_cnt_ff == 4'(lpm_pkg::RST_SEQ_CYCLES - 1));

   // pin low boots flash
   wire [1:0] boot_map = !boot_pin ? lpm_pkg::BOOT_FLASH :
      boot_opt ? lpm_pkg::BOOT_MEM : lpm_pkg::BOOT_SRAM;

   // next state; reset pin and watchdog win
   always_comb begin
      nxt_state = state_ff;
      if (force_reset) begin
         nxt_state = lpm_pkg::ST_RESET;
      end else begin
         case (state_ff)
            lpm_pkg::ST_RESET: begin
               if (seq_done) begin
                  nxt_state = lpm_pkg::ST_RUN;
               end
            end
            lpm_pkg::ST_RUN: begin
               if (core_sleep_req_in) begin
                  if (!ctrl_ff[lpm_pkg::CTRL_DEEP_BIT]) begin
                     nxt_state = lpm_pkg::ST_SLEEP;
                  end else if (ctrl_ff[lpm_pkg::CTRL_STBY_BIT]) begin
                     nxt_state = lpm_pkg::ST_STBY;
                  end else begin
                     nxt_state = lpm_pkg::ST_DEEP;
                  end
               end
            end
            lpm_pkg::ST_SLEEP: begin
               if (core_event_in | any_pend) begin
                  nxt_state = lpm_pkg::ST_RUN;
               end
            end
            lpm_pkg::ST_DEEP: begin
               if (any_pend) begin
                  nxt_state = lpm_pkg::ST_RUN;
               end
            end
            lpm_pkg::ST_STBY: begin
               if (stby_wake) begin
                  nxt_state = lpm_pkg::ST_RESET;
               end
            end
            default: begin
               nxt_state = lpm_pkg::ST_RESET;
            end
         endcase
      end
   end

   // always-on state; a held reset pin keeps the count at zero
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_ff <= lpm_pkg::ST_RESET;
         seq_cnt_ff <= 4'h0;
         boot_ff <= lpm_pkg::BOOT_FLASH;
         stby_flag_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         seq_cnt_ff <= (state_ff == lpm_pkg::ST_RESET && !seq_done && !force_reset) ? seq_cnt_ff + 4'h1 : 4'h0;
         if (state_ff == lpm_pkg::ST_RESET && seq_done && !force_reset) begin
            boot_ff <= boot_map;
         end
         if (state_ff == lpm_pkg::ST_STBY && nxt_state == lpm_pkg::ST_RESET) begin
            stby_flag_ff <= 1'b1;
         end else if (wr_en & sel_stat & hwdata_in[lpm_pkg::STAT_STBY_BIT]) begin
            stby_flag_ff <= 1'b0;
         end
      end
   end

   // reset sequence wipes config; always-on flops survive
   wire cfg_wipe = !rst_n_in || state_ff == lpm_pkg::ST_RESET;
   // deep exit falls back to internal oscillator, pll and crystal enable bits kept
   wire deep_exit = (state_ff == lpm_pkg::ST_DEEP) && (nxt_state == lpm_pkg::ST_RUN);

   // software config
   always_ff @(posedge clk_in) begin
      if (cfg_wipe) begin
         ctrl_ff <= lpm_pkg::CTRL_RST;
         rise_ff <= lpm_pkg::LINE_RST;
         fall_ff <= lpm_pkg::LINE_RST;
         mask_ff <= lpm_pkg::LINE_RST;
         pinen_ff <= lpm_pkg::PINEN_RST;
      end else begin
         if (wr_en & sel_ctrl) begin
            ctrl_ff <= hwdata_in[7:0];
         end else if (deep_exit) begin
            ctrl_ff[lpm_pkg::CTRL_CLK_LSB +: 2] <= lpm_pkg::CLK_FAST_OSC;
         end
         if (wr_en & sel_rise) begin
            rise_ff <= hwdata_in[19:0];
         end
         if (wr_en & sel_fall) begin
            fall_ff <= hwdata_in[19:0];
         end
         if (wr_en & sel_mask) begin
            mask_ff <= hwdata_in[19:0];
         end
         if (wr_en & sel_pinen) begin
            pinen_ff <= hwdata_in[3:0];
         end
      end
   end

   // state decode
   wire in_reset = (state_ff == lpm_pkg::ST_RESET);
   wire in_run = (state_ff == lpm_pkg::ST_RUN);
   wire in_sleep = (state_ff == lpm_pkg::ST_SLEEP);
   wire in_deep = (state_ff == lpm_pkg::ST_DEEP);
   wire in_stby = (state_ff == lpm_pkg::ST_STBY);
   wire clocks_on = in_reset | in_run | in_sleep;

   // power-down code refused, treated as normal
   wire [1:0] deep_reg = ctrl_ff[lpm_pkg::CTRL_REG_LSB +: 2];
   wire [1:0] deep_mode = (deep_reg == lpm_pkg::REG_OFF) ? lpm_pkg::REG_NORMAL : deep_reg;

   assign regulator_mode_out = in_stby ? lpm_pkg::REG_OFF :
      in_deep ? deep_mode :
      lpm_pkg::REG_NORMAL;
   assign domain_power_out = ~in_stby;
   assign retain_out = ~in_stby;
   assign core_halt_out = ~in_run;
   assign sys_reset_n_out = ~(in_reset | in_stby);
   assign internal_fast_osc_en_out = clocks_on;
   assign pll_en_out = clocks_on & ctrl_ff[lpm_pkg::CTRL_PLL_BIT];
   assign external_fast_crystal_en_out = clocks_on & ctrl_ff[lpm_pkg::CTRL_XTAL_BIT];
   // slow clocks never stop
   assign calendar_clock_clk_en_out = 1'b1;
   assign independent_watchdog_clk_en_out = 1'b1;
   assign boot_source_out = boot_ff;
   // internal oscillator over six in reset, stale config cannot leak in
   assign sysclk_src_out = in_reset ? lpm_pkg::CLK_FAST_OSC : ctrl_ff[lpm_pkg::CTRL_CLK_LSB +: 2];
   assign sysclk_div_out = (sysclk_src_out == lpm_pkg::CLK_FAST_OSC) ?
      lpm_pkg::SYSCLK_DIV_RST : lpm_pkg::SYSCLK_DIV_ONE;
   assign pm_state_out = state_ff;
endmodule // low_power_mode_controller

// ---- core/lpm_pkg.sv ----
// power-mode controller constants and types
package lpm_pkg;
   localparam int unsigned CLK_MHZ = 40; // system clock rate
   localparam int unsigned WAKE_LINES = 20; // 16 pins plus 4 internal
   localparam int unsigned EXT_LINES = 16; // pin lines
   localparam int unsigned WAKE_PINS = 4; // standby wake pins
   localparam int unsigned AW = 12; // decoded address bits
   // register byte offsets
   localparam logic [11:0] CTRL_OFS = 12'h000; // mode control
   localparam logic [11:0] RISE_OFS = 12'h004; // rising-edge enables
   localparam logic [11:0] FALL_OFS = 12'h008; // falling-edge enables
   localparam logic [11:0] MASK_OFS = 12'h00c; // line enables
   localparam logic [11:0] PEND_OFS = 12'h010; // pending
   localparam logic [11:0] STAT_OFS = 12'h014; // state and boot status
   localparam logic [11:0] PINEN_OFS = 12'h018; // wake pin enables
   // control field positions
   localparam int unsigned CTRL_DEEP_BIT = 0; // sleep request goes deep
   localparam int unsigned CTRL_STBY_BIT = 1; // deep request goes to standby
   localparam int unsigned CTRL_REG_LSB = 2; // deep regulator mode
   localparam int unsigned CTRL_XTAL_BIT = 4; // crystal enable
   localparam int unsigned CTRL_PLL_BIT = 5; // pll enable
   localparam int unsigned CTRL_CLK_LSB = 6; // clock source
   localparam int unsigned CTRL_W = 8; // control width
   localparam int unsigned STAT_BOOT_LSB = 4; // boot source field
   localparam int unsigned STAT_STBY_BIT = 8; // woke from standby
   // values after reset
   localparam logic [7:0] CTRL_RST = 8'h00; // all off, internal clock
   localparam logic [19:0] LINE_RST = 20'h00000; // edge and mask enables
   localparam logic [3:0] PINEN_RST = 4'h0; // wake pins disabled
   localparam logic [7:0] PIN_SYNC_RST = 8'h10; // reset pin idles high
   // reset sequence length
   localparam int unsigned RST_SEQ_NS = 200; // core held in reset
   localparam int unsigned RST_SEQ_CYCLES = (RST_SEQ_NS * CLK_MHZ + 999) / 1000;
   // default clock
   localparam int unsigned FAST_OSC_MHZ = 48; // fast oscillator
   localparam int unsigned SYSCLK_MHZ = 8; // default system clock
   localparam logic [2:0] SYSCLK_DIV_RST = 3'(FAST_OSC_MHZ / SYSCLK_MHZ);
   localparam logic [2:0] SYSCLK_DIV_ONE = 3'h1; // undivided sources
   typedef enum logic [1:0] {
      REG_NORMAL = 2'b00,
      REG_LOW = 2'b01,
      REG_XLOW = 2'b10,
      REG_OFF = 2'b11
   } reg_mode_t;
   typedef enum logic [2:0] {
      ST_RESET = 3'b000,
      ST_RUN = 3'b001,
      ST_SLEEP = 3'b010,
      ST_DEEP = 3'b011,
      ST_STBY = 3'b100
   } pm_state_t;
   typedef enum logic [1:0] {
      BOOT_FLASH = 2'b00,
      BOOT_MEM = 2'b01,
      BOOT_SRAM = 2'b10
   } boot_src_t;
   typedef enum logic [1:0] {
      CLK_FAST_OSC = 2'b00,
      CLK_CRYSTAL = 2'b01,
      CLK_PLL = 2'b10
   } clk_src_t;
endpackage

// ---- core/wake_line_detect.sv ----
// wake lines: sync, edge select, mask, pending
module wake_line_detect (
   input wire logic clk_in, // system clock
   input wire logic rst_n_in, // sync reset, active low
   input wire logic [19:0] line_in, // asynchronous line levels
   input wire logic [19:0] rise_en_in, // rising enables
   input wire logic [19:0] fall_en_in, // falling enables
   input wire logic [19:0] mask_in, // line enables
   input wire logic [19:0] clr_in, // pending clear pulses
   output logic [19:0] pend_out, // pending flags
   output logic [19:0] rise_evt_out // raw rising edges
);
   logic [19:0] meta_ff; // first stage
   logic [19:0] sync_ff; // second stage
   logic [19:0] prev_ff; // last synced level
   logic [19:0] pend_ff; // pending flags

   genvar i;
   generate
      for (i = 0; i < 20; i++) begin : g_line
         wire rise = sync_ff[i] & ~prev_ff[i]; // level went up
         wire fall = ~sync_ff[i] & prev_ff[i]; // level went down
         wire hit = mask_in[i] & ((rise & rise_en_in[i]) | (fall & fall_en_in[i]));
         // set beats clear
         always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
               meta_ff[i] <= 1'b0;
               sync_ff[i] <= 1'b0;
               prev_ff[i] <= 1'b0;
               pend_ff[i] <= 1'b0;
            end else begin
               meta_ff[i] <= line_in[i];
               sync_ff[i] <= meta_ff[i];
               prev_ff[i] <= sync_ff[i];
               pend_ff[i] <= (pend_ff[i] & ~clr_in[i]) | hit;
            end
         end
         assign rise_evt_out[i] = rise;
      end
   endgenerate

   assign pend_out = pend_ff;
endmodule // wake_line_detect

// ---- core/ahb_word_port.sv ----
// ahb-lite slave: writes zero wait, reads one wait
module ahb_word_port (
   input wire logic clk_in, // system clock
   input wire logic rst_n_in, // sync reset, active low
   input wire logic hsel_in, // slave select
   input wire logic [31:0] haddr_in, // address
   input wire logic [1:0] htrans_in, // transfer type
   input wire logic hwrite_in, // write when high
   input wire logic [2:0] hsize_in, // transfer size
   input wire logic hready_in, // bus ready
   input wire logic [31:0] rdata_in, // register read data
   output logic [11:0] addr_out, // captured offset
   output logic wr_en_out, // write strobe
   output logic rd_en_out, // read capture
   output logic [31:0] hrdata_out, // read data
   output logic hreadyout_out, // slave ready
   output logic hresp_out // always okay
);
   logic [11:0] addr_ff; // data-phase offset
   logic wr_ff; // write pending
   logic rd_ff; // read wait cycle
   logic [31:0] rdata_ff; // registered read data

   // transfer taken
   wire take = hsel_in & htrans_in[1] & hready_in;
   // narrower writes dropped
   wire word = (hsize_in == 3'h2);

   // read stalls a cycle while the read data is captured into rdata_ff
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         addr_ff <= 12'h000;
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
      end else begin
         if (take) begin
            addr_ff <= haddr_in[11:0];
         end
         wr_ff <= take & hwrite_in & word;
         rd_ff <= take & ~hwrite_in;
         if (rd_ff) begin
            rdata_ff <= rdata_in;
         end
      end
   end

   assign addr_out = addr_ff;
   assign wr_en_out = wr_ff;
   assign rd_en_out = rd_ff;
   assign hrdata_out = rdata_ff;
   assign hreadyout_out = ~rd_ff;
   assign hresp_out = 1'b0;
endmodule // ahb_word_port

// ---- verif/lpm_checker_asserts.sv ----
// power-state assertions
module lpm_checker (
   input wire logic clk_in, // clock
   input wire logic rst_n_in, // sync reset
   input wire logic core_event_in, // core event
   input wire logic core_halt_out, // core halted
   input wire logic sys_reset_n_out, // system reset
   input wire logic [1:0] regulator_mode_out, // regulator
   input wire logic domain_power_out, // domain power
   input wire logic retain_out, // retention
   input wire logic pll_en_out, // pll
   input wire logic internal_fast_osc_en_out, // fast osc
   input wire logic external_fast_crystal_en_out, // crystal
   input wire logic calendar_clock_clk_en_out, // calendar clk
   input wire logic independent_watchdog_clk_en_out, // watchdog clk
   input wire logic [1:0] sysclk_src_out, // clk source
   input wire logic [2:0] sysclk_div_out, // divider
   input wire logic [2:0] pm_state_out // state
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // reset sequence then run
   AST_RST_SEQ: assert property ($rose(rst_n_in) |->
      (pm_state_out == lpm_pkg::ST_RESET && regulator_mode_out == 2'h0)[*7] ##[1:3] pm_state_out == lpm_pkg::ST_RUN)
      else $error("reset sequence wrong");
   AST_CLK_DEF: assert property (pm_state_out == lpm_pkg::ST_RESET |->
      sysclk_src_out == 2'h0 && sysclk_div_out == 3'h6) else $error("default clock wrong");
   AST_SLEEP_WAKE: assert property (pm_state_out == lpm_pkg::ST_SLEEP && core_event_in |=>
      pm_state_out == lpm_pkg::ST_RUN) else $error("event did not end sleep");
   AST_HALT: assert property (core_halt_out != (pm_state_out == lpm_pkg::ST_RUN))
      else $error("halt not tied to run");
   AST_REG_RUN: assert property (pm_state_out inside {lpm_pkg::ST_RUN, lpm_pkg::ST_SLEEP} |->
      regulator_mode_out == 2'h0) else $error("regulator not normal");
   AST_REG_LOW: assert property (regulator_mode_out inside {2'h1, 2'h2} |->
      pm_state_out == lpm_pkg::ST_DEEP) else $error("low regulator outside deepsleep");
   AST_DEEP: assert property (pm_state_out == lpm_pkg::ST_DEEP |-> !pll_en_out &&
      !internal_fast_osc_en_out && !external_fast_crystal_en_out && retain_out) else $error("deepsleep clocks");
   AST_STBY: assert property (pm_state_out == lpm_pkg::ST_STBY |-> regulator_mode_out == 2'h3 &&
      !domain_power_out && !retain_out && !sys_reset_n_out && !pll_en_out && !internal_fast_osc_en_out)
      else $error("standby power wrong");
   AST_AO_CLK: assert property (calendar_clock_clk_en_out && independent_watchdog_clk_en_out)
      else $error("always-on clock stopped");
   // main scenarios reached
   COV_SLEEP: cover property (pm_state_out == lpm_pkg::ST_SLEEP);
   COV_DEEP: cover property (pm_state_out == lpm_pkg::ST_DEEP);
   COV_STBY: cover property (pm_state_out == lpm_pkg::ST_STBY);
endmodule // lpm_checker
bind low_power_mode_controller lpm_checker i_chk (.clk_in, .rst_n_in, .core_event_in, .core_halt_out,
   .sys_reset_n_out, .regulator_mode_out, .domain_power_out, .retain_out, .pll_en_out, .internal_fast_osc_en_out,
   .external_fast_crystal_en_out, .calendar_clock_clk_en_out, .independent_watchdog_clk_en_out, .sysclk_src_out,
   .sysclk_div_out, .pm_state_out);

// ---- verif/core_wake_model.sv ----
// partner: core requests and wake lines
module core_wake_model (
   input wire logic clk_in, // clock
   input wire logic sleep_go_in, // bench asks for sleep
   input wire logic event_go_in, // bench asks for event
   input wire logic [19:0] line_lvl_in, // wanted line levels
   output logic sleep_req_out, // one-cycle request
   output logic event_out, // event level
   output logic [19:0] line_out // wake lines
);
   logic go_ff; // last request level
   // one request per rise
   always_ff @(posedge clk_in) begin
      go_ff <= sleep_go_in;
   end
   assign sleep_req_out = sleep_go_in & ~go_ff;
   assign event_out = event_go_in;
   assign line_out = line_lvl_in;
endmodule // core_wake_model

// ---- verif/test_low_power_mode_controller.sv ----
// testbench for the power-mode controller
module test_low_power_mode_controller;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'h0, rst_n_in = 1'h0, hsel_in = 1'h0, hwrite_in = 1'h0, sgo = 1'h0, ego = 1'h0;
   logic external_reset_pin_n_in = 1'h1, independent_watchdog_reset_in = 1'h0;
   logic boot_select_pin_in = 1'h0, boot_option_bit_in = 1'h0;
   logic [1:0] htrans_in = 2'h0;
   logic [2:0] hsize_in = 3'h2;
   logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, rd_q;
   logic [19:0] lines = 20'h0, wl;
   logic [3:0] wake_pin_in = 4'h0;
   logic hreadyout_out, core_halt_out, sys_reset_n_out, pll_en_out, sreq, cev;
   logic [1:0] regulator_mode_out, boot_source_out, sysclk_src_out;
   logic [2:0] sysclk_div_out, pm_state_out;
   wire logic hready_in = hreadyout_out; // single slave
   integer n_errors = 0, n_tests = 0, cyc = 0, seed = 32'h2009, i, l, e;
   low_power_mode_controller i_dut (.clk_in, .rst_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in,
      .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out(), .core_sleep_req_in(sreq),
      .core_event_in(cev), .external_interrupt_line_in(wl[15:0]), .supply_voltage_monitor_in(wl[16]),
      .calendar_clock_alarm_in(wl[17]), .calendar_clock_tamper_in(1'h0), .calendar_clock_stamp_in(wl[18]),
      .analog_comparator_wake_in(wl[19]), .external_reset_pin_n_in, .independent_watchdog_reset_in, .wake_pin_in,
      .boot_select_pin_in, .boot_option_bit_in, .core_halt_out, .sys_reset_n_out, .regulator_mode_out,
      .domain_power_out(), .retain_out(), .pll_en_out, .internal_fast_osc_en_out(),
      .external_fast_crystal_en_out(), .calendar_clock_clk_en_out(), .independent_watchdog_clk_en_out(),
      .boot_source_out, .sysclk_src_out, .sysclk_div_out, .pm_state_out);
   core_wake_model i_core (.clk_in, .sleep_go_in(sgo), .event_go_in(ego), .line_lvl_in(lines),
      .sleep_req_out(sreq), .event_out(cev), .line_out(wl));
   initial begin
      forever #12.5 clk_in = ~clk_in;
   end
   // expected boot source
   function automatic logic [1:0] boot_exp(input logic p, input logic o);
      return !p ? 2'h0 : (o ? 2'h1 : 2'h2);
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // wait for ready, keep read data
   task rdy;
      do @(negedge clk_in); while (hreadyout_out !== 1'h1);
      rd_q = hrdata_out;
      @(posedge clk_in);
   endtask
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel_in <= 1'h1;
      haddr_in <= {20'h0, a};
      htrans_in <= 2'h2;
      hwrite_in <= w;
      rdy();
      htrans_in <= 2'h0;
      hsel_in <= 1'h0;
      hwdata_in <= d;
      rdy();
   endtask
   // bounded state wait
   task wst(input logic [2:0] s, input integer n);
      integer k;
      k = 0;
      do begin @(negedge clk_in); k++; end while (pm_state_out !== s && k < n);
      chk(pm_state_out, s);
      @(posedge clk_in);
   endtask
   task slp;
      sgo <= 1'h1;
      @(posedge clk_in);
      sgo <= 1'h0;
   endtask
   task stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // hang guard
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         stop_test();
      end
   end
   initial begin
      for (i = 0; i < 4; i++) begin
         boot_select_pin_in <= i[1];
         boot_option_bit_in <= i[0];
         rst_n_in <= 1'h0;
         repeat (20) @(posedge clk_in);
         rst_n_in <= 1'h1;
         wst(lpm_pkg::ST_RUN, 12);
         chk(boot_source_out, boot_exp(i[1], i[0]));
      end
      $display("boot test done");
      slp();
      wst(lpm_pkg::ST_SLEEP, 4);
      chk(core_halt_out, 1'h1);
      ego <= 1'h1;
      wst(lpm_pkg::ST_RUN, 4);
      ego <= 1'h0;
      $display("sleep test done");
      // deep regulator codes 0 to 2, random line, edge
      for (i = 0; i < 3; i++) begin
         l = {$random(seed)} % 20;
         e = {$random(seed)} % 2;
         lines <= e[0] ? 20'h0 : 20'hfffff;
         repeat (4) @(posedge clk_in);
         bus(1'h1, lpm_pkg::RISE_OFS, 32'(e[0]) << l);
         bus(1'h1, lpm_pkg::FALL_OFS, 32'(!e[0]) << l);
         bus(1'h1, lpm_pkg::MASK_OFS, 32'h1 << l);
         bus(1'h1, lpm_pkg::PEND_OFS, 32'hfffff);
         bus(1'h1, lpm_pkg::CTRL_OFS, 32'h71 | (i << 2));
         #1 chk(pll_en_out, 1'h1);
         slp();
         wst(lpm_pkg::ST_DEEP, 4);
         chk(regulator_mode_out, i);
         lines <= lines ^ (20'h1 << ((l + 1) % 20));
         repeat (6) @(posedge clk_in);
         chk(pm_state_out, lpm_pkg::ST_DEEP);
         lines[l] <= e[0];
         wst(lpm_pkg::ST_RUN, 8);
         bus(1'h0, lpm_pkg::PEND_OFS, 32'h0);
         chk(rd_q & (32'h1 << l), 32'h1 << l);
      end
      $display("deepsleep test done");
      l = {$random(seed)} % 4;
      bus(1'h1, lpm_pkg::PINEN_OFS, 32'h1 << l);
      bus(1'h1, lpm_pkg::CTRL_OFS, 32'h3);
      slp();
      wst(lpm_pkg::ST_STBY, 4);
      chk(regulator_mode_out, 2'h3);
      wake_pin_in <= 4'h1 << ((l + 1) % 4);
      repeat (6) @(posedge clk_in);
      chk(pm_state_out, lpm_pkg::ST_STBY);
      wake_pin_in <= 4'h1 << l;
      wst(lpm_pkg::ST_RESET, 6);
      wst(lpm_pkg::ST_RUN, 12);
      wake_pin_in <= 4'h0;
      bus(1'h0, lpm_pkg::STAT_OFS, 32'h0);
      chk(rd_q[8], 1'h1);
      bus(1'h0, lpm_pkg::CTRL_OFS, 32'h0);
      chk(rd_q, 32'h0);
      $display("standby test done");
      // reset pin, then watchdog, from run
      for (i = 0; i < 2; i++) begin
         external_reset_pin_n_in <= i[0];
         independent_watchdog_reset_in <= i[0];
         wst(lpm_pkg::ST_RESET, 6);
         external_reset_pin_n_in <= 1'h1;
         independent_watchdog_reset_in <= 1'h0;
         wst(lpm_pkg::ST_RUN, 16);
      end
      bus(1'h0, 12'h100, 32'h0);
      chk(rd_q, 32'h0);
      $display("reset source test done");
      stop_test();
   end
endmodule // test_low_power_mode_controller
